/* core/reset_combiner_pkg.sv */
// Package: register map, field layout, reset values and enums
// for the reset source combiner. Assumes a 32-bit AXI4-Lite bus.
package reset_combiner_pkg;

    localparam int ADDR_W = 8;
    localparam int NCAUSE = 9;

    // Register byte offsets
    localparam logic [7:0] OFF_STATUS  = 8'h00;
    localparam logic [7:0] OFF_OSC     = 8'h04;
    localparam logic [7:0] OFF_RTC_CAL = 8'h08;
    localparam logic [7:0] OFF_NVM_CTL = 8'h0c;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h14;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h18;
    localparam logic [7:0] OFF_SCRATCH = 8'h1c;
    localparam logic [7:0] OFF_STATE   = 8'h20;

    // Cause bit positions in status and interrupt registers
    localparam int BIT_BROWNOUT = 0;
    localparam int BIT_POWER_ON = 1;
    localparam int BIT_EXT_PIN  = 2;
    localparam int BIT_SW_INSTR = 3;
    localparam int BIT_WATCHDOG = 4;
    localparam int BIT_CFG_MIS  = 5;
    localparam int BIT_TRAP     = 6;
    localparam int BIT_ILL_OP   = 7;
    localparam int BIT_UNINIT_W = 8;

    // Oscillator control fields
    localparam int OSC_SEL_LSB  = 0;
    localparam int OSC_SEL_W    = 3;
    localparam int OSC_FAIL_BIT = 3;
    localparam logic [2:0] OSC_SEL_FAST_RC = 3'h0;

    // Control register fields
    localparam int CTL_MON_EN_BIT = 0;

    // Reset values
    localparam logic [8:0]  STATUS_POR_VALUE = 9'h003;
    localparam logic [15:0] RTC_CAL_RESET    = 16'h0000;
    localparam logic [15:0] NVM_CTL_RESET    = 16'h0000;
    localparam logic [8:0]  IRQ_MSK_RESET    = 9'h000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SEQ_HOLD      = 2'b00,
        SEQ_WAIT_CLK  = 2'b01,
        SEQ_RUN       = 2'b11
    } seq_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              valid;
    } axi_addr_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
        logic        valid;
    } axi_wdata_t;

endpackage

/* core/reset_source_combiner.sv */
// Reset source combiner: merges nine reset causes into one master
// reset, records causes, applies type-dependent register resets and
// gates core start on a valid clock. Assumes aresetn is power-on reset.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns

module reset_source_combiner
    import reset_combiner_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              external_reset_pin,
    input  wire logic              software_reset_instruction,
    input  wire logic              watchdog_timeout_cause,
    input  wire logic              brownout_reset_cause,
    input  wire logic              config_mismatch_cause,
    input  wire logic              trap_conflict_cause,
    input  wire logic              illegal_opcode_cause,
    input  wire logic              uninit_wreg_cause,
    input  wire logic [2:0]        initial_oscillator_select,
    input  wire logic              clock_source_valid,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   master_system_reset,
    output logic                   core_run_enable,
    output logic                   fast_rc_selected,
    output logic                   irq
);

    typedef struct packed {
        seq_state_t  seq;
        logic        mrst;
        logic        run;
        logic        fast_internal_rc_oscillator;
        logic        irq;
        logic [8:0]  status;
        logic [2:0]  osc_sel;
        logic        osc_fail;
        logic [15:0] rtc_cal;
        logic [15:0] nvm_ctl;
        logic        mon_en;
        logic [8:0]  irq_st;
        logic [8:0]  irq_msk;
        logic [31:0] scratch;
        axi_addr_t   aw;
        axi_wdata_t  w;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_t;

    state_t st;
    state_t next_st;

    logic [NCAUSE-1:0] cause;

    ////////////////////////////////////////////////////////////////////
    // Cause vector, power-on is taken by aresetn itself

    always_comb begin
        cause                = '0;
        cause[BIT_EXT_PIN]   = external_reset_pin;
        cause[BIT_SW_INSTR]  = software_reset_instruction;
        cause[BIT_WATCHDOG]  = watchdog_timeout_cause;
        cause[BIT_BROWNOUT]  = brownout_reset_cause;
        cause[BIT_CFG_MIS]   = config_mismatch_cause;
        cause[BIT_TRAP]      = trap_conflict_cause;
        cause[BIT_ILL_OP]    = illegal_opcode_cause;
        cause[BIT_UNINIT_W]  = uninit_wreg_cause;
    end

    ////////////////////////////////////////////////////////////////////
    // Byte-lane merge

    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a == OFF_STATUS) || (a == OFF_OSC) || (a == OFF_RTC_CAL)
          || (a == OFF_NVM_CTL) || (a == OFF_CONTROL)
          || (a == OFF_IRQ_ST) || (a == OFF_IRQ_MSK)
          || (a == OFF_SCRATCH) || (a == OFF_STATE);
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic        any_cause;
        logic        do_write;
        logic [31:0] wv;
        logic [8:0]  status_w;
        logic [8:0]  irq_st_w;
        next_st   = st;
        any_cause = |cause;
        do_write  = 1'b0;
        wv        = '0;
        status_w  = st.status;
        irq_st_w  = st.irq_st;

        // Write channels taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw.addr  = s_axi_awaddr;
            next_st.aw.valid = 1'b1;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w.data  = s_axi_wdata;
            next_st.w.strb  = s_axi_wstrb;
            next_st.w.valid = 1'b1;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Response waits until both halves are in
        if (st.aw.valid && st.w.valid && !st.bvalid) begin
            do_write         = 1'b1;
            next_st.aw.valid = 1'b0;
            next_st.w.valid  = 1'b0;
            next_st.bvalid   = 1'b1;
            next_st.bresp    = mapped(st.aw.addr) ? RESP_OKAY
                                                  : RESP_SLVERR;
        end

        // Register writes; status bits are plain storage
        if (do_write) begin
            case (st.aw.addr)
                OFF_STATUS: begin
                    wv       = merge_lanes({23'h0, st.status},
                                           st.w.data, st.w.strb);
                    status_w = wv[8:0];
                end
                OFF_OSC: begin
                    wv = merge_lanes({28'h0, st.osc_fail, st.osc_sel},
                                     st.w.data, st.w.strb);
                    next_st.osc_sel  = wv[OSC_SEL_LSB +: OSC_SEL_W];
                    next_st.osc_fail = wv[OSC_FAIL_BIT];
                end
                OFF_RTC_CAL: begin
                    wv = merge_lanes({16'h0, st.rtc_cal},
                                     st.w.data, st.w.strb);
                    next_st.rtc_cal = wv[15:0];
                end
                OFF_NVM_CTL: begin
                    wv = merge_lanes({16'h0, st.nvm_ctl},
                                     st.w.data, st.w.strb);
                    next_st.nvm_ctl = wv[15:0];
                end
                OFF_CONTROL: begin
                    wv = merge_lanes({31'h0, st.mon_en},
                                     st.w.data, st.w.strb);
                    next_st.mon_en = wv[CTL_MON_EN_BIT];
                end
                OFF_IRQ_ST: begin
                    wv = merge_lanes(32'h0, st.w.data, st.w.strb);
                    irq_st_w = st.irq_st & ~wv[8:0];
                end
                OFF_IRQ_MSK: begin
                    wv = merge_lanes({23'h0, st.irq_msk},
                                     st.w.data, st.w.strb);
                    next_st.irq_msk = wv[8:0];
                end
                OFF_SCRATCH: begin
                    next_st.scratch = merge_lanes(st.scratch,
                                                  st.w.data, st.w.strb);
                end
                default: begin
                    wv = '0;
                end
            endcase
        end

        // Hardware set wins over a same-cycle software clear
        next_st.status = status_w | cause;
        next_st.irq_st = irq_st_w | cause;

        // Read channel
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // Read data captured with the address, held until taken
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = mapped(s_axi_araddr) ? RESP_OKAY
                                                  : RESP_SLVERR;
            case (s_axi_araddr)
                OFF_STATUS:  next_st.rdata = {23'h0, st.status};
                OFF_OSC:     next_st.rdata = {28'h0, st.osc_fail,
                                              st.osc_sel};
                OFF_RTC_CAL: next_st.rdata = {16'h0, st.rtc_cal};
                OFF_NVM_CTL: next_st.rdata = {16'h0, st.nvm_ctl};
                OFF_CONTROL: next_st.rdata = {31'h0, st.mon_en};
                OFF_IRQ_ST:  next_st.rdata = {23'h0, st.irq_st};
                OFF_IRQ_MSK: next_st.rdata = {23'h0, st.irq_msk};
                OFF_SCRATCH: next_st.rdata = st.scratch;
                OFF_STATE:   next_st.rdata = {29'h0, st.fast_internal_rc_oscillator, st.run,
                                              st.mrst};
                default:     next_st.rdata = 32'h0;
            endcase
        end

        // Reset sequencer
        case (st.seq)
            SEQ_HOLD: begin
                next_st.run = 1'b0;
                if (!any_cause) begin
                    next_st.mrst = 1'b0;
                    next_st.seq  = SEQ_WAIT_CLK;
                    // Monitor looks at the clock at release
                    if (st.mon_en && !clock_source_valid) begin
                        next_st.osc_sel  = OSC_SEL_FAST_RC;
                        next_st.osc_fail = 1'b1;
                        next_st.fast_internal_rc_oscillator      = 1'b1;
                    end
                    // Enable dropped once the release check is done
                    next_st.mon_en = 1'b0;
                end
            end
            SEQ_WAIT_CLK: begin
                // Clock may still be starting here
                if (clock_source_valid || st.fast_internal_rc_oscillator) begin
                    next_st.run = 1'b1;
                    next_st.seq = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                next_st.run = 1'b1;
            end
            default: begin
                next_st.seq = SEQ_HOLD;
            end
        endcase

        // Any source forces master reset, overriding the sequencer
        if (any_cause) begin
            next_st.mrst    = 1'b1;
            next_st.run     = 1'b0;
            next_st.seq     = SEQ_HOLD;
            next_st.fast_internal_rc_oscillator     = 1'b0;
            // Monitor enable kept so the release check still sees it
            // and the sequencer drops it afterwards
            next_st.osc_sel = initial_oscillator_select;
            // rtc_cal, nvm_ctl and scratch kept on this reset
        end
        if (next_st.osc_sel != OSC_SEL_FAST_RC) begin
            next_st.fast_internal_rc_oscillator = 1'b0;
        end

        // Handshake readiness for the next cycle
        next_st.awready = !next_st.aw.valid && !next_st.bvalid;
        next_st.wready  = !next_st.w.valid && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
        // Registered level of unmasked sticky bits
        next_st.irq     = |(next_st.irq_st & next_st.irq_msk);
    end

    ////////////////////////////////////////////////////////////////////
    // State register; aresetn acts as power-on reset

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st          <= '0;
            st.seq      <= SEQ_HOLD;
            st.mrst     <= 1'b1;
            st.status   <= STATUS_POR_VALUE;
            st.irq_st   <= STATUS_POR_VALUE;
            st.irq_msk  <= IRQ_MSK_RESET;
            st.rtc_cal  <= RTC_CAL_RESET;
            st.nvm_ctl  <= NVM_CTL_RESET;
            st.osc_sel  <= OSC_SEL_FAST_RC;
            st.osc_fail <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Power-on leaves the fast RC select in place; the configured
    // select is loaded only when a reset source fires, since the
    // reset branch may assign constants only. Calibration and
    // nonvolatile control are cleared here and nowhere else.

    assign s_axi_awready       = st.awready;
    assign s_axi_wready        = st.wready;
    assign s_axi_bvalid        = st.bvalid;
    assign s_axi_bresp         = st.bresp;
    assign s_axi_arready       = st.arready;
    assign s_axi_rvalid        = st.rvalid;
    assign s_axi_rdata         = st.rdata;
    assign s_axi_rresp         = st.rresp;
    assign master_system_reset = st.mrst;
    assign core_run_enable     = st.run;
    assign fast_rc_selected    = st.fast_internal_rc_oscillator;
    assign irq                 = st.irq;

endmodule // reset_source_combiner

/* test/reset_source_combiner_properties.sv */
// Checker: port-level timing of the reset source combiner.
// Assumes it is bound to reset_source_combiner; one clock domain.
`timescale 1ns/1ns
module reset_source_combiner_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic external_reset_pin,
    input wire logic software_reset_instruction,
    input wire logic watchdog_timeout_cause,
    input wire logic brownout_reset_cause,
    input wire logic config_mismatch_cause,
    input wire logic trap_conflict_cause,
    input wire logic illegal_opcode_cause,
    input wire logic uninit_wreg_cause,
    input wire logic clock_source_valid,
    input wire logic master_system_reset,
    input wire logic core_run_enable,
    input wire logic fast_rc_selected
);
    logic any_cause;
    assign any_cause = external_reset_pin | software_reset_instruction
        | watchdog_timeout_cause | brownout_reset_cause
        | config_mismatch_cause | trap_conflict_cause
        | illegal_opcode_cause | uninit_wreg_cause;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////
    sequence s_quiet;
        $past(aresetn) && !any_cause;
    endsequence
    sequence s_release;
        $fell(master_system_reset) ##0 (clock_source_valid && !any_cause);
    endsequence

    property p_cause_asserts;
        any_cause |=> master_system_reset;
    endproperty
    a_cause_asserts: assert property (p_cause_asserts)
        else $error("Source did not assert master reset");
    property p_quiet_release;
        s_quiet |=> !master_system_reset;
    endproperty
    a_quiet_release: assert property (p_quiet_release)
        else $error("Master reset held with no source");
    property p_fell_cause;
        $fell(master_system_reset) |-> !$past(any_cause);
    endproperty
    a_fell_cause: assert property (p_fell_cause)
        else $error("Master reset fell while a source was active");
    property p_run_gated;
        core_run_enable |-> !master_system_reset;
    endproperty
    a_run_gated: assert property (p_run_gated)
        else $error("Core runs during master reset");
    property p_run_start;
        s_release |=> core_run_enable;
    endproperty
    a_run_start: assert property (p_run_start)
        else $error("Core did not start with a valid clock");
    property p_rise_stops;
        $rose(master_system_reset) |-> !core_run_enable;
    endproperty
    a_rise_stops: assert property (p_rise_stops)
        else $error("Core kept running into reset");
    property p_clk_wait;
        !clock_source_valid && !fast_rc_selected && !core_run_enable
            |=> !core_run_enable;
    endproperty
    a_clk_wait: assert property (p_clk_wait)
        else $error("Core started without a valid clock");
    property p_frc;
        $rose(fast_rc_selected)
            |-> $fell(master_system_reset) && !$past(clock_source_valid);
    endproperty
    a_frc: assert property (p_frc)
        else $error("Fast RC fallback at the wrong moment");
endmodule // reset_source_combiner_properties

bind reset_source_combiner reset_source_combiner_properties
    reset_source_combiner_properties_i (
        .aclk, .aresetn, .external_reset_pin, .software_reset_instruction,
        .watchdog_timeout_cause, .brownout_reset_cause,
        .config_mismatch_cause, .trap_conflict_cause,
        .illegal_opcode_cause, .uninit_wreg_cause, .clock_source_valid,
        .master_system_reset, .core_run_enable, .fast_rc_selected
    );

/* test/reset_source_model.sv */
// Partner model: reset sources and oscillator start-up.
// Assumes the bench strobes fire and oscillator requests at edges.
`timescale 1ns/1ns
module reset_source_model #(
    parameter int STARTUP = 6
) (
    input  wire logic       aclk,
    input  wire logic       fire,
    input  wire logic [2:0] which,
    input  wire logic [3:0] hold,
    input  wire logic       osc_kick,
    input  wire logic       osc_off,
    output logic      [7:0] causes,
    output logic            clk_valid
);
    logic [3:0] left [8];
    int         osc_cnt = 0;
    bit         osc_on = 1'b0;

    initial for (int j = 0; j < 8; j++) left[j] = 4'h0;

    // Each source is a level held for a chosen count
    always @(posedge aclk) begin
        for (int j = 0; j < 8; j++) begin
            if (left[j] != 4'h0) left[j] <= left[j] - 4'h1;
        end
        if (fire) left[which] <= hold;
        // Start-up runs apart from any reset
        if (osc_off) begin
            osc_on <= 1'b0;
            osc_cnt <= 0;
        end else if (osc_kick) osc_on <= 1'b1;
        else if (osc_on && osc_cnt < STARTUP) osc_cnt <= osc_cnt + 1;
    end

    always_comb begin
        for (int j = 0; j < 8; j++) causes[j] = left[j] != 4'h0;
    end
    assign clk_valid = osc_on && osc_cnt >= STARTUP;
endmodule // reset_source_model

/* test/reset_source_combiner_tb.sv */
// Bench: drives reset sources and the register bus of the combiner.
// Assumes the package and the partner model of sources and clock.
`timescale 1ns/1ns
module reset_source_combiner_tb
    import reset_combiner_pkg::*;
;
    localparam int STARTUP = 6;
    logic              aclk, aresetn, fire, osc_kick, osc_off, irq;
    logic [7:0]        causes;
    logic [2:0]        which, initial_oscillator_select;
    logic [3:0]        hold, s_axi_wstrb;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic              s_axi_rready, master_system_reset;
    logic              core_run_enable, fast_rc_selected, clock_source_valid;
    int                err_count = 0;
    int                tests_run = 0;

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    reset_source_model #(.STARTUP(STARTUP)) reset_source_model_i (
        .aclk, .fire, .which, .hold, .osc_kick, .osc_off, .causes,
        .clk_valid(clock_source_valid)
    );

    reset_source_combiner reset_source_combiner_i (
        .aclk, .aresetn, .initial_oscillator_select, .clock_source_valid,
        .brownout_reset_cause(causes[0]), .external_reset_pin(causes[1]),
        .software_reset_instruction(causes[2]),
        .watchdog_timeout_cause(causes[3]),
        .config_mismatch_cause(causes[4]), .trap_conflict_cause(causes[5]),
        .illegal_opcode_cause(causes[6]), .uninit_wreg_cause(causes[7]),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .master_system_reset, .core_run_enable,
        .fast_rc_selected, .irq
    );

    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic step(inout int n);
        @(posedge aclk);
        n++;
        if (n > 60) begin
            err_count++;
            $display("Error at %0t: wait ran out", $time);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            step(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            step(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask

    // Fire one source, then wait for master reset to rise and fall
    task automatic reset_by(input int j, input logic [3:0] len);
        int n;
        n = 0;
        @(posedge aclk);
        which <= 3'(j);
        hold <= len;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        while (master_system_reset !== 1'b1) step(n);
        while (master_system_reset !== 1'b0) step(n);
    endtask

    task automatic osc(input logic on);
        @(posedge aclk);
        osc_kick <= on;
        osc_off <= !on;
        @(posedge aclk);
        osc_kick <= 1'b0;
        osc_off <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, fire, which, hold, osc_off} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        osc_kick = 1'b1;
        initial_oscillator_select = 3'h5;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        osc_kick <= 1'b0;
        repeat (2) @(posedge aclk);
        rd(OFF_STATUS, 32'h3, RESP_OKAY);
        rd(OFF_NVM_CTL, 32'h0, RESP_OKAY);
        wr(OFF_RTC_CAL, 32'h1234, RESP_OKAY);
        wr(OFF_NVM_CTL, 32'h00aa, RESP_OKAY);
        wr(OFF_SCRATCH, 32'ha5a5_0f0f, RESP_OKAY);
        for (int j = 0; j < 8; j++) begin
            wr(OFF_STATUS, 32'h0, RESP_OKAY);
            reset_by(j, 4'h2);
            rd(OFF_STATUS, 32'h1 << (j == 0 ? 0 : j + 1), RESP_OKAY);
        end
        rd(OFF_RTC_CAL, 32'h1234, RESP_OKAY);
        rd(OFF_NVM_CTL, 32'h00aa, RESP_OKAY);
        rd(OFF_SCRATCH, 32'ha5a5_0f0f, RESP_OKAY);
        rd(OFF_OSC, 32'h5, RESP_OKAY);
        wr(OFF_STATUS, 32'h1ff, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk(32'(master_system_reset), 32'h0);
        rd(OFF_STATUS, 32'h1ff, RESP_OKAY);
        wr(OFF_IRQ_ST, 32'h1ff, RESP_OKAY);
        rd(OFF_IRQ_ST, 32'h0, RESP_OKAY);
        wr(OFF_IRQ_MSK, 32'h10, RESP_OKAY);
        reset_by(1, 4'h2);
        chk(32'(irq), 32'h0);
        reset_by(3, 4'h2);
        chk(32'(irq), 32'h1);
        wr(OFF_IRQ_ST, 32'h10, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        rd(OFF_IRQ_ST, 32'h4, RESP_OKAY);
        // Overlapping sources keep master reset up
        reset_by(1, 4'h3);
        @(posedge aclk);
        fire <= 1'b1;
        hold <= 4'h8;
        which <= 3'h3;
        @(posedge aclk);
        fire <= 1'b0;
        which <= 3'h1;
        hold <= 4'h4;
        repeat (2) @(posedge aclk);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(32'(master_system_reset), 32'h1);
        osc(1'b0);
        reset_by(1, 4'h2);
        repeat (3) @(posedge aclk);
        chk(32'(core_run_enable), 32'h0);
        osc(1'b1);
        repeat (STARTUP + 4) @(posedge aclk);
        chk(32'(core_run_enable), 32'h1);
        wr(OFF_CONTROL, 32'h1, RESP_OKAY);
        osc(1'b0);
        reset_by(1, 4'h2);
        repeat (2) @(posedge aclk);
        chk({30'h0, fast_rc_selected, core_run_enable}, 32'h3);
        rd(OFF_OSC, 32'h8, RESP_OKAY);
        rd(OFF_CONTROL, 32'h0, RESP_OKAY);
        wr(OFF_OSC, 32'h5, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(fast_rc_selected), 32'h0);
        osc(1'b1);
        rd(OFF_STATE, 32'h2, RESP_OKAY);
        // Mid-run power-on restores status and calibration
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(OFF_STATUS, 32'h3, RESP_OKAY);
        rd(OFF_RTC_CAL, 32'h0, RESP_OKAY);
        rd(8'h24, 32'h0, RESP_SLVERR);
        wr(8'h24, 32'hffff_ffff, RESP_SLVERR);
        end_of_test();
    end
endmodule // reset_source_combiner_tb
